// ### fwh_pkg.sv
package fwh_pkg;
	// Word framing
	localparam int WORD_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] LAST_BIT = 4'hF;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// Timing
	localparam int CLK_HZ = 100000000;
	localparam int NOT_READY_MS = 500;
	localparam int NOT_READY_CYC = NOT_READY_MS * (CLK_HZ / 1000);
	localparam int SYNC_STAGES = 2;
	// Link selection switch value for the local driver set
	localparam logic LINK_LOCAL = 1'b0;
	// Synchroniser lane positions inside one driver set
	localparam int LN_REQ = 0;
	localparam int LN_STB = 1;
	localparam int LN_DAT = 2;
	localparam int LN_LST = 3;
	localparam int LANES = 4;

	typedef enum logic [1:0] {TX_IDLE, TX_WAIT_REQ, TX_STROBE} fwh_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_REQ, RX_ACK} fwh_rx_state_t;

	// Serial order: low byte bit 7 first down to 0, then bits 15 to 8
	function automatic logic [3:0] fwh_bit_pos(input logic [3:0] cnt);
		fwh_bit_pos = {cnt[3], ~cnt[2:0]};
	endfunction : fwh_bit_pos
endpackage : fwh_pkg

// ### fwh_sync.sv
`timescale 1ns/1ps
module fwh_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2
) (
	input wire logic ref_clk_i, // Clock
	input wire logic rst_b_i, // Async reset, active low
	input wire logic clk_en_i, // Clock enable
	input wire logic [WIDTH-1:0] async_i, // Raw inputs
	output logic [WIDTH-1:0] sync_o // Synchronised inputs
);
	logic [STAGES*WIDTH-1:0] chain_q;
	logic [STAGES*WIDTH-1:0] chain_d;

	// Refuse chains too short to settle metastability
	if (STAGES < 2) begin : g_chk
		$error("fwh_sync needs at least two stages");
	end

	// Shift each lane one stage onward
	always_comb begin
		chain_d = {chain_q[(STAGES-1)*WIDTH-1:0], async_i};
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			chain_q <= '0;
		end else if (clk_en_i) begin
			chain_q <= chain_d;
		end
	end

	assign sync_o = chain_q[STAGES*WIDTH-1 -: WIDTH];
endmodule : fwh_sync

// ### fwh_line_unit.sv
`timescale 1ns/1ps
// What this block does
// - Buffer-empty set at reset/clear and after a whole word is sent.
// - High byte write clears buffer-empty; bit one is strobed once remote ready is seen.
// - Transmitter drops strobe after remote drops its ready line.
// - Per-bit handshake repeats for 16 bits, then buffer-empty sets.
// - Receiver idles after clear; get-word raises our request line.
// - Remote answers request with strobe and data; we capture the bit.
// - After capture we drop request; remote then drops its strobe.
// - Re-request per bit until 16; then no request, set data-available.
// - Strobe is raised only while the receiver's ready line is true.
// - Ready drops only after data taken and while strobe is true.
// - Strobe drops after ready falls; new ready only after strobe low.
// - Switch picks local or distant drivers; only that set is active.
// - Reading high received byte clears data-available; low byte does not.
// - Final-bit enable, self clearing, raises last-bit on sixteenth bit.
// - Remote last-bit sets message end, reported with data-available.
// - Not-ready clears 500 ms after remote ready; holds line error set.
module fwh_line_unit
	import fwh_pkg::*;
#(
	parameter int NOT_READY_CYCLES = NOT_READY_CYC
) (
	input wire logic ref_clk_i, // 100 MHz clock
	input wire logic rst_b_i, // Async reset, active low
	input wire logic clk_en_i, // Freezes all state when low
	input wire logic [7:0] tx_byte_i, // Transmit byte data
	input wire logic tx_low_wr_i, // Write low transmit byte
	input wire logic tx_high_wr_i, // Write high byte, starts word
	input wire logic final_bit_set_i, // Set final-bit enable
	input wire logic tx_clear_i, // Transmit clear level
	input wire logic err_clear_i, // Error clear toggle level
	input wire logic rx_clear_i, // Receive clear level
	input wire logic host_ready_i, // Host online request
	input wire logic get_word_i, // Get-word command pulse
	input wire logic rx_high_rd_i, // Read of high received byte
	input wire logic link_select_i, // 0 local, 1 distant
	input wire logic [3:0] loc_link_i, // Local rx: last,data,strb,req
	input wire logic [3:0] dist_link_i, // Distant rx: last,data,strb,req
	input wire logic remote_ready_i, // Remote relay closed
	output logic [3:0] loc_link_o, // Local tx: last,data,strb,req
	output logic [3:0] dist_link_o, // Distant tx: last,data,strb,req
	output logic host_ready_o, // Host relay drive
	output logic [7:0] rx_low_byte_o, // Received low byte
	output logic [7:0] rx_high_byte_o, // Received high byte
	output logic buffer_empty_o, // Transmit buffer empty
	output logic data_avail_o, // Received word ready
	output logic message_end_flag_o, // Remote last bit seen
	output logic line_error_o, // Line error flag
	output logic remote_not_ready_o, // Remote offline
	output logic remote_bit_request_o, // Remote ready-for-bit
	output logic final_bit_enable_o // Final-bit enable state
);
	localparam int NRW = $clog2(NOT_READY_CYCLES + 1);

	if (NOT_READY_CYCLES < 1) begin : g_chk
		$error("NOT_READY_CYCLES must be at least one");
	end

	logic [2*LANES:0] sync_s;
	logic [LANES-1:0] link_s;
	logic req_s, stb_s, dat_s, lst_s, rdy_s;

	fwh_sync #(.WIDTH(2*LANES+1), .STAGES(SYNC_STAGES)) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i),
		.async_i({dist_link_i, loc_link_i, remote_ready_i}),
		.sync_o(sync_s)
	);

	assign link_s = (link_select_i == LINK_LOCAL) ? sync_s[LANES:1] :
		sync_s[2*LANES:LANES+1];
	assign req_s = link_s[LN_REQ];
	assign stb_s = link_s[LN_STB];
	assign dat_s = link_s[LN_DAT];
	assign lst_s = link_s[LN_LST];
	assign rdy_s = sync_s[0];

	// Transmit state
	fwh_tx_state_t tx_st_q, tx_st_d;
	logic [3:0] tx_cnt_q, tx_cnt_d;
	logic [15:0] tx_word_q, tx_word_d;
	logic tx_stb_q, tx_stb_d, tx_dat_q, tx_dat_d, tx_lst_q, tx_lst_d;
	logic empty_q, empty_d, fbe_q, fbe_d, armed_q, armed_d;

	// Transmit next state
	always_comb begin
		tx_st_d = tx_st_q;
		tx_cnt_d = tx_cnt_q;
		tx_word_d = tx_word_q;
		tx_stb_d = tx_stb_q;
		tx_dat_d = tx_dat_q;
		tx_lst_d = tx_lst_q;
		empty_d = empty_q;
		armed_d = armed_q;
		fbe_d = fbe_q | final_bit_set_i;
		if (tx_low_wr_i) begin
			tx_word_d[7:0] = tx_byte_i;
		end
		if (tx_clear_i) begin
			tx_st_d = TX_IDLE;
			tx_cnt_d = 4'h0;
			tx_stb_d = 1'b0;
			tx_dat_d = 1'b0;
			tx_lst_d = 1'b0;
			empty_d = 1'b1;
			armed_d = 1'b0;
			fbe_d = 1'b0;
		end else begin
			unique case (tx_st_q)
				TX_IDLE: begin
					if (tx_high_wr_i && empty_q) begin
						tx_word_d[15:8] = tx_byte_i;
						empty_d = 1'b0;
						armed_d = fbe_q;
						fbe_d = final_bit_set_i;
						tx_cnt_d = 4'h0;
						tx_st_d = TX_WAIT_REQ;
					end
				end
				TX_WAIT_REQ: begin
					if (req_s) begin
						tx_dat_d = tx_word_q[fwh_bit_pos(tx_cnt_q)];
						tx_lst_d = armed_q && (tx_cnt_q == LAST_BIT);
						tx_stb_d = 1'b1;
						tx_st_d = TX_STROBE;
					end
				end
				TX_STROBE: begin
					if (!req_s) begin
						tx_stb_d = 1'b0;
						tx_lst_d = 1'b0;
						if (tx_cnt_q == LAST_BIT) begin
							empty_d = 1'b1;
							armed_d = 1'b0;
							tx_st_d = TX_IDLE;
						end else begin
							tx_cnt_d = tx_cnt_q + 4'h1;
							tx_st_d = TX_WAIT_REQ;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_st_q <= TX_IDLE;
			tx_cnt_q <= 4'h0;
			tx_word_q <= WORD_RST;
			tx_stb_q <= 1'b0;
			tx_dat_q <= 1'b0;
			tx_lst_q <= 1'b0;
			empty_q <= 1'b1;
			armed_q <= 1'b0;
			fbe_q <= 1'b0;
		end else if (clk_en_i) begin
			tx_st_q <= tx_st_d;
			tx_cnt_q <= tx_cnt_d;
			tx_word_q <= tx_word_d;
			tx_stb_q <= tx_stb_d;
			tx_dat_q <= tx_dat_d;
			tx_lst_q <= tx_lst_d;
			empty_q <= empty_d;
			armed_q <= armed_d;
			fbe_q <= fbe_d;
		end
	end

	// Receive state
	fwh_rx_state_t rx_st_q, rx_st_d;
	logic [3:0] rx_cnt_q, rx_cnt_d;
	logic [15:0] rx_word_q, rx_word_d;
	logic rx_req_q, rx_req_d, eom_q, eom_d;
	logic avail_q, avail_d, mend_q, mend_d;

	// Receive next state
	always_comb begin
		rx_st_d = rx_st_q;
		rx_cnt_d = rx_cnt_q;
		rx_word_d = rx_word_q;
		rx_req_d = rx_req_q;
		eom_d = eom_q;
		avail_d = avail_q;
		mend_d = mend_q;
		if (rx_high_rd_i) begin
			avail_d = 1'b0;
			mend_d = 1'b0;
		end
		if (rx_clear_i) begin
			rx_st_d = RX_IDLE;
			rx_cnt_d = 4'h0;
			rx_word_d = WORD_RST;
			rx_req_d = 1'b0;
			eom_d = 1'b0;
			avail_d = 1'b0;
			mend_d = 1'b0;
		end else begin
			unique case (rx_st_q)
				RX_IDLE: begin
					if (get_word_i) begin
						rx_req_d = 1'b1;
						rx_cnt_d = 4'h0;
						eom_d = 1'b0;
						rx_st_d = RX_REQ;
					end
				end
				RX_REQ: begin
					if (stb_s) begin
						rx_word_d[fwh_bit_pos(rx_cnt_q)] = dat_s;
						eom_d = eom_q | lst_s;
						rx_req_d = 1'b0;
						rx_st_d = RX_ACK;
					end
				end
				RX_ACK: begin
					// next request only after strobe low
					if (!stb_s) begin
						if (rx_cnt_q == LAST_BIT) begin
							avail_d = 1'b1;
							mend_d = eom_q;
							rx_st_d = RX_IDLE;
						end else begin
							rx_cnt_d = rx_cnt_q + 4'h1;
							rx_req_d = 1'b1;
							rx_st_d = RX_REQ;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 4'h0;
			rx_word_q <= WORD_RST;
			rx_req_q <= 1'b0;
			eom_q <= 1'b0;
			avail_q <= 1'b0;
			mend_q <= 1'b0;
		end else if (clk_en_i) begin
			rx_st_q <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_word_q <= rx_word_d;
			rx_req_q <= rx_req_d;
			eom_q <= eom_d;
			avail_q <= avail_d;
			mend_q <= mend_d;
		end
	end

	// Line status state
	logic nr_q, nr_d, err_q, err_d, eclr_q, host_q, host_d;
	logic [NRW-1:0] nr_cnt_q, nr_cnt_d;

	always_comb begin
		nr_d = nr_q;
		nr_cnt_d = nr_cnt_q;
		err_d = err_q;
		host_d = host_ready_i & ~rx_clear_i;
		if (!rdy_s) begin
			nr_d = 1'b1;
			nr_cnt_d = '0;
		end else if (nr_q) begin
			if (nr_cnt_q == NRW'(NOT_READY_CYCLES - 1)) begin
				nr_d = 1'b0;
			end else begin
				nr_cnt_d = nr_cnt_q + 1'b1;
			end
		end
		if (eclr_q && !err_clear_i && !nr_q) begin
			err_d = 1'b0;
		end
		if (nr_q || !rdy_s) begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nr_q <= 1'b1;
			nr_cnt_q <= '0;
			err_q <= 1'b1;
			eclr_q <= 1'b0;
			host_q <= 1'b0;
		end else if (clk_en_i) begin
			nr_q <= nr_d;
			nr_cnt_q <= nr_cnt_d;
			err_q <= err_d;
			eclr_q <= err_clear_i;
			host_q <= host_d;
		end
	end

	logic [LANES-1:0] tx_lanes;
	assign tx_lanes = {tx_lst_q, tx_dat_q, tx_stb_q, rx_req_q};
	assign loc_link_o = (link_select_i == LINK_LOCAL) ? tx_lanes : '0;
	assign dist_link_o = (link_select_i == LINK_LOCAL) ? '0 : tx_lanes;

	// Status outputs
	assign host_ready_o = host_q;
	assign rx_low_byte_o = rx_word_q[7:0];
	assign rx_high_byte_o = rx_word_q[15:8];
	assign buffer_empty_o = empty_q;
	assign data_avail_o = avail_q;
	assign message_end_flag_o = mend_q;
	assign line_error_o = err_q;
	assign remote_not_ready_o = nr_q;
	assign remote_bit_request_o = req_s;
	assign final_bit_enable_o = fbe_q;

	AST_START_CLEARS_EMPTY: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		clk_en_i && !tx_clear_i && tx_high_wr_i && empty_q
		|=> !empty_q && tx_st_q == TX_WAIT_REQ
	) else $error("high byte write did not start a word");

	AST_STROBE_NEEDS_REQ: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(tx_stb_q) |-> $past(req_s)
	) else $error("strobe raised without remote request");

	// strobe falls only after request low
	AST_STROBE_DROP: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$fell(tx_stb_q) && !$past(tx_clear_i) |-> !$past(req_s)
	) else $error("strobe dropped while request still high");

	AST_WORD_DONE_EMPTY: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		clk_en_i && tx_st_q == TX_STROBE && tx_cnt_q == LAST_BIT && !req_s
		|=> empty_q && !tx_stb_q
	) else $error("buffer empty not set after sixteenth bit");

	// last-bit line only on sixteenth bit
	AST_LAST_ON_FINAL: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		tx_lst_q |-> tx_stb_q && tx_cnt_q == LAST_BIT
	) else $error("last-bit line outside sixteenth bit");

	AST_GET_WORD_REQ: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		clk_en_i && !rx_clear_i && get_word_i && rx_st_q == RX_IDLE
		|=> rx_req_q
	) else $error("get-word did not raise the request");

	// request drops only while strobe high
	AST_REQ_DROP: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$fell(rx_req_q) && !$past(rx_clear_i) |-> $past(stb_s)
	) else $error("request dropped without strobe");

	AST_NO_REQ_AFTER_WORD: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(avail_q) |-> !rx_req_q && rx_cnt_q == LAST_BIT
	) else $error("data available without sixteen bits");

	AST_HIGH_READ_CLEARS: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		clk_en_i && rx_high_rd_i && rx_st_q != RX_ACK |=> !avail_q && !mend_q
	) else $error("high byte read left flags set");

	AST_NOT_READY_ERROR: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		nr_q |-> err_q
	) else $error("line error clear while remote not ready");
endmodule : fwh_line_unit

// ### fwh_remote_model.sv
`timescale 1ns/1ps
module fwh_remote_model (
	input wire logic ref_clk_i, // Clock
	input wire logic rst_b_i, // Reset, active low
	input wire logic restart_i, // Start a new word each way
	input wire logic stall_i, // Hold back this cycle
	input wire logic [3:0] unit_link_i, // Unit lines of chosen set
	input wire logic [15:0] send_word_i, // Word sent to unit
	input wire logic [4:0] last_at_i, // Index that raises last
	output logic [3:0] link_o, // Lines to unit
	output logic [15:0] got_word_o, // Word taken from unit
	output logic [4:0] got_last_o, // Index of first last bit
	output logic [4:0] got_cnt_o // Bits taken
);
	logic req_q, stb_q, dat_q, lst_q;
	logic [4:0] sent_q;
	logic [3:0] pos_t, pos_r;
	assign link_o = {lst_q, dat_q, stb_q, req_q};
	// Serial index to bit position, low byte first, msb first
	assign pos_t = {got_cnt_o[3], ~got_cnt_o[2:0]};
	assign pos_r = {sent_q[3], ~sent_q[2:0]};
	// Both handshakes of the remote processor
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i || restart_i) begin
			req_q <= 1'b0;
			stb_q <= 1'b0;
			dat_q <= 1'b0;
			lst_q <= 1'b0;
			sent_q <= 5'h00;
			got_word_o <= 16'h0000;
			got_last_o <= 5'h1F;
			got_cnt_o <= 5'h00;
		end else if (!stall_i) begin
			// take bit, drop, re-request on low strobe
			if (req_q && unit_link_i[1]) begin
				got_word_o[pos_t] <= unit_link_i[2];
				if (unit_link_i[3] && got_last_o == 5'h1F) begin
					got_last_o <= got_cnt_o;
				end
				got_cnt_o <= got_cnt_o + 5'h01;
				req_q <= 1'b0;
			end else if (!unit_link_i[1] && got_cnt_o < 5'h10) begin
				req_q <= 1'b1;
			end
			// bit only while asked, released after
			if (!stb_q && unit_link_i[0] && sent_q < 5'h10) begin
				dat_q <= send_word_i[pos_r];
				lst_q <= (sent_q == last_at_i);
				stb_q <= 1'b1;
			end else if (stb_q && !unit_link_i[0]) begin
				stb_q <= 1'b0;
				dat_q <= ~dat_q; // Released line shows inverse
				lst_q <= 1'b0;
				sent_q <= sent_q + 5'h01;
			end
		end
	end
endmodule : fwh_remote_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
	localparam int NRC = 20;
	logic ref_clk_i, rst_b_i, clk_en_i, tx_low_wr_i, tx_high_wr_i;
	logic final_bit_set_i, tx_clear_i, err_clear_i, rx_clear_i;
	logic host_ready_i, get_word_i, rx_high_rd_i, link_select_i;
	logic remote_ready_i, host_ready_o, buffer_empty_o, data_avail_o;
	logic message_end_flag_o, line_error_o, remote_not_ready_o;
	logic remote_bit_request_o, final_bit_enable_o;
	logic [7:0] tx_byte_i, rx_low_byte_o, rx_high_byte_o;
	logic [3:0] loc_link_i, dist_link_i, loc_link_o, dist_link_o;
	logic [3:0] m_link, unit_link, noise;
	logic restart, stall, mon_on, p_stb, p_rdy;
	logic [15:0] send_w, got_w;
	logic [4:0] last_at, got_last, got_cnt;
	int failures, samples_checked, i;

	fwh_line_unit #(.NOT_READY_CYCLES(NRC)) u_fwh_line_unit (.ref_clk_i,
		.rst_b_i, .clk_en_i, .tx_byte_i, .tx_low_wr_i, .tx_high_wr_i,
		.final_bit_set_i, .tx_clear_i, .err_clear_i, .rx_clear_i,
		.host_ready_i, .get_word_i, .rx_high_rd_i, .link_select_i,
		.loc_link_i, .dist_link_i, .remote_ready_i, .loc_link_o,
		.dist_link_o, .host_ready_o, .rx_low_byte_o, .rx_high_byte_o,
		.buffer_empty_o, .data_avail_o, .message_end_flag_o, .line_error_o,
		.remote_not_ready_o, .remote_bit_request_o, .final_bit_enable_o);
	fwh_remote_model u_fwh_remote_model (.ref_clk_i, .rst_b_i,
		.restart_i(restart), .stall_i(stall), .unit_link_i(unit_link),
		.send_word_i(send_w), .last_at_i(last_at), .link_o(m_link),
		.got_word_o(got_w), .got_last_o(got_last), .got_cnt_o(got_cnt));

	// only the chosen set meets the remote
	assign loc_link_i = link_select_i ? noise : m_link;
	assign dist_link_i = link_select_i ? m_link : noise;
	assign unit_link = link_select_i ? dist_link_o : loc_link_o;

	// Clock and noise on the unused set
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(negedge ref_clk_i) noise <= 4'($urandom);

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	// Serial index of the first last-bit the remote should see
	function automatic logic [4:0] exp_last(input logic fl);
		return fl ? 5'h0F : 5'h1F;
	endfunction : exp_last

	// Message end expected when the remote marks a bit of the word
	function automatic logic exp_end(input logic [4:0] la);
		return la < 5'h10;
	endfunction : exp_end

	task automatic final_report();
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	// Watchdog sized well beyond all transfers
	initial begin
		repeat (90000) @(posedge ref_clk_i);
		failures++;
		final_report();
	end

	// Handshake order seen on the wire, sampled once settled
	always @(negedge ref_clk_i) begin
		if (mon_on) begin
			if (unit_link[1] && !p_stb) check("strobe rise", m_link[0], 1);
			if (!unit_link[1] && p_stb) check("strobe fall", m_link[0], 0);
			if (!unit_link[0] && p_rdy) check("ready fall", m_link[1], 1);
			if (unit_link[0] && !p_rdy) check("ready rise", m_link[1], 0);
		end
		p_stb <= unit_link[1];
		p_rdy <= unit_link[0];
	end

	task automatic online();
		remote_ready_i = 1'b1;
		repeat (NRC - 1) @(negedge ref_clk_i);
		check("still not ready", remote_not_ready_o, 1);
		repeat (6) @(negedge ref_clk_i);
		check("not ready clear", remote_not_ready_o, 0);
		check("error held", line_error_o, 1);
		err_clear_i = 1'b1;
		@(negedge ref_clk_i);
		err_clear_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		check("error cleared", line_error_o, 0);
	endtask : online

	task automatic xfer(input logic [15:0] tw, input logic fl,
		input logic [15:0] rw, input logic [4:0] la);
		int n;
		send_w = rw;
		last_at = la;
		restart = 1'b1;
		final_bit_set_i = fl;
		@(negedge ref_clk_i);
		restart = 1'b0;
		final_bit_set_i = 1'b0;
		check("final enable", final_bit_enable_o, fl);
		check("host up", host_ready_o, 1);
		// low byte first, then high byte with get-word
		tx_byte_i = tw[7:0];
		tx_low_wr_i = 1'b1;
		@(negedge ref_clk_i);
		tx_low_wr_i = 1'b0;
		tx_byte_i = tw[15:8];
		tx_high_wr_i = 1'b1;
		get_word_i = 1'b1;
		@(negedge ref_clk_i);
		get_word_i = 1'b0;
		check("empty after load", buffer_empty_o, 0);
		check("enable cleared", final_bit_enable_o, 0);
		tx_byte_i = ~tw[15:8]; // Refused while busy
		@(negedge ref_clk_i);
		tx_high_wr_i = 1'b0;
		n = 0;
		while (!(buffer_empty_o === 1'b1 && data_avail_o === 1'b1) && n < 3000) begin
			clk_en_i = ($urandom % 8) != 0;
			stall = 1'($urandom);
			check("unused set", link_select_i ? loc_link_o : dist_link_o, 0);
			@(negedge ref_clk_i);
			n++;
		end
		clk_en_i = 1'b1;
		stall = 1'b0;
		check("word done", {buffer_empty_o, data_avail_o}, 2'h3);
		check("word sent", got_w, tw);
		check("bits sent", got_cnt, 16);
		check("last index", got_last, exp_last(fl));
		check("rx word", {rx_high_byte_o, rx_low_byte_o}, rw);
		check("msg end", message_end_flag_o, exp_end(la));
		repeat (8) @(negedge ref_clk_i);
		check("no request", unit_link[0], 0);
		check("remote idle", remote_bit_request_o, 0);
		rx_high_rd_i = 1'b1;
		@(negedge ref_clk_i);
		rx_high_rd_i = 1'b0;
		@(negedge ref_clk_i);
		check("avail cleared", data_avail_o, 0);
		check("msg cleared", message_end_flag_o, 0);
	endtask : xfer

	// Main sequence
	initial begin
		{rst_b_i, tx_low_wr_i, tx_high_wr_i, final_bit_set_i} = 4'h0;
		{tx_clear_i, err_clear_i, rx_clear_i, host_ready_i} = 4'h0;
		{get_word_i, rx_high_rd_i, link_select_i, remote_ready_i} = 4'h0;
		{restart, stall, mon_on} = 3'h0;
		clk_en_i = 1'b1;
		tx_byte_i = 8'h00;
		send_w = 16'h0000;
		last_at = 5'h1F;
		failures = 0;
		samples_checked = 0;
		void'($urandom(55771));
		repeat (20) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		@(negedge ref_clk_i);
		check("empty at reset", buffer_empty_o, 1);
		check("rx idle", {unit_link, data_avail_o}, 0);
		online();
		remote_ready_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		check("error on drop", line_error_o, 1);
		// Clear toggle is refused while the remote is not ready
		err_clear_i = 1'b1;
		@(negedge ref_clk_i);
		err_clear_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		check("error kept", line_error_o, 1);
		online();
		check("remote request", remote_bit_request_o, 1);
		host_ready_i = 1'b1;
		mon_on = 1'b1;
		xfer(16'h8001, 1'b1, 16'hFFFF, 5'h07);
		xfer(16'h0000, 1'b0, 16'h0000, 5'h1F);
		for (i = 0; i < 12; i++) begin
			link_select_i = i[0];
			@(negedge ref_clk_i);
			xfer(16'($urandom), 1'($urandom), 16'($urandom), 5'($urandom));
		end
		rx_clear_i = 1'b1;
		final_bit_set_i = 1'b1;
		@(negedge ref_clk_i);
		final_bit_set_i = 1'b0;
		tx_clear_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		check("rx cleared", {rx_high_byte_o, rx_low_byte_o}, 0);
		check("host dropped", host_ready_o, 0);
		check("tx cleared", {buffer_empty_o, final_bit_enable_o}, 2);
		{rx_clear_i, tx_clear_i} = 2'b00;
		@(negedge ref_clk_i);
		xfer(16'h5AA5, 1'b1, 16'hC33C, 5'h0F);
		final_report();
	end
endmodule : tb
